// *** core/priority_interrupt_controller.sv ***
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
module priority_interrupt_controller
    import intc_pkg::*;
(
    // clocking
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdata,
    // peripheral and trap requests, asynchronous pins
    input wire logic [NUM_SRC-1:0] srcReq,
    input wire logic [NUM_TRAP-1:0] trapReq,
    // core handshake, same clock
    input wire logic vectorAck,
    input wire logic returnInstr,
    input wire logic timedDisableInstr,
    // vector to core
    output logic vectorValid,
    output logic [LVL_W:0] vectorNum,
    output logic [LVL_W-1:0] cpuLevel,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    // request synchronisers
    logic [NUM_SRC-1:0] srcMeta, srcSync, srcLast;
    logic [NUM_TRAP-1:0] trapMeta, trapSync, trapLast;

    // two stages before anything looks at the pins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            srcMeta <= '0;
            srcSync <= '0;
            srcLast <= '0;
            trapMeta <= '0;
            trapSync <= '0;
            trapLast <= '0;
        end else if (ce) begin
            srcMeta <= srcReq;
            srcSync <= srcMeta;
            srcLast <= srcSync;
            trapMeta <= trapReq;
            trapSync <= trapMeta;
            trapLast <= trapSync;
        end
    end

    logic [NUM_SRC-1:0] srcRise;
    logic [NUM_TRAP-1:0] trapRise;
    assign srcRise = srcSync & ~srcLast;
    assign trapRise = trapSync & ~trapLast;

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [NUM_SRC-1:0] flags, next_flags;
    logic [NUM_SRC-1:0] enables, next_enables;
    logic [NUM_SRC*PRIO_W-1:0] prios, next_prios;
    logic nestDisable, next_nestDisable;
    logic [NUM_TRAP-1:0] trapFlags, next_trapFlags;
    logic [7:0] statusLow, next_statusLow;
    logic [DIS_W-1:0] disCount, next_disCount;
    logic [NUM_EV-1:0] irqStat, next_irqStat;
    logic [NUM_EV-1:0] irqMask, next_irqMask;
    logic wrHit;
    logic [NUM_EV-1:0] events;
    logic entryTake;

    assign wrHit = regWr;
    // level field sits in bits 3:1 so that an or of 0Eh lifts it to seven
    assign cpuLevel = {1'b0, statusLow[3:1]};

    ctx_if ctx();
    ctx_stack #(.DEPTH(STACK_DEPTH)) uStack (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .ctx(ctx)
    );

    ////////////////////////////////////////////////////////////////////////
    // arbitration
    logic [LVL_W-1:0] bestLvl;
    logic [SRC_W-1:0] bestSrc;
    logic bestAny;
    logic [TRAP_W-1:0] bestTrap;
    logic trapAny;
    logic [LVL_W-1:0] effLevel;

    // per-source request level: zero unless flagged and enabled
    logic [LVL_W-1:0] srcLvl [NUM_SRC];
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : gLvl
            assign srcLvl[gi] = (flags[gi] && enables[gi])
                ? {1'b0, prios[gi*PRIO_W +: PRIO_W]} : 4'h0;
        end
    endgenerate

    // scan from high index down so the lowest number wins ties
    always_comb begin
        bestLvl = 4'h0;
        bestSrc = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (srcLvl[i] != 4'h0 && srcLvl[i] >= bestLvl) begin
                bestLvl = srcLvl[i];
                bestSrc = SRC_W'(i);
            end
        end
        bestAny = (bestLvl != 4'h0);
        bestTrap = '0;
        trapAny = 1'b0;
        for (int t = 0; t < NUM_TRAP; t++) begin
            if (trapFlags[t]) begin
                bestTrap = TRAP_W'(t);
                trapAny = 1'b1;
            end
        end
    end

    // threshold the user winner must beat
    always_comb begin
        effLevel = cpuLevel;
        if (nestDisable && !ctx.empty) begin
            effLevel = LVL_MAX_USER;
        end
        if (disCount != '0 && effLevel < LVL_DISABLE_TOP) begin
            effLevel = LVL_DISABLE_TOP;
        end
    end

    // traps ignore every mask; users must exceed the threshold
    always_comb begin
        vectorValid = 1'b0;
        vectorNum = '0;
        if (trapAny) begin
            vectorValid = 1'b1;
            vectorNum = {1'b1, 1'b0, bestTrap};
        end else if (bestAny && bestLvl > effLevel) begin
            vectorValid = 1'b1;
            vectorNum = {1'b0, bestSrc};
        end
    end

    assign entryTake = vectorValid && vectorAck && !ctx.full;
    // save status on every entry; on user entries with no return in the same cycle, raise level to the vectored source
    assign ctx.push = entryTake;
    assign ctx.pushData = statusLow;
    assign ctx.pop = returnInstr && !ctx.empty;

    ////////////////////////////////////////////////////////////////////////
    // next-state for all register state
    always_comb begin
        next_flags = flags | srcRise;
        next_enables = enables;
        next_prios = prios;
        next_nestDisable = nestDisable;
        next_trapFlags = trapFlags | trapRise;
        next_statusLow = statusLow;
        next_disCount = (disCount != '0) ? disCount - 1'b1 : disCount;
        next_irqMask = irqMask;
        events = '0;
        if (wrHit) begin
            case (regAddr)
                OFF_FLAGS: next_flags = regWdata | srcRise;
                OFF_ENABLE: next_enables = regWdata;
                OFF_PRIO0, OFF_PRIO1, OFF_PRIO2, OFF_PRIO3: begin
                    for (int k = 0; k < 4; k++) begin
                        next_prios[(int'(regAddr - OFF_PRIO0) * 4 + k) * PRIO_W +: PRIO_W] =
                            regWdata[k*4 +: PRIO_W];
                    end
                end
                OFF_CONTROL: begin
                    next_nestDisable = regWdata[CTL_NEST_DIS];
                    next_trapFlags = (trapFlags & regWdata[CTL_TRAP_LSB +: NUM_TRAP]) | trapRise;
                end
                // OR of 0Eh lands the level field at seven
                OFF_CPU_LVL: next_statusLow = regWdata[7:0];
                OFF_IRQ_MASK: next_irqMask = regWdata[NUM_EV-1:0];
                default: ;
            endcase
        end
        if (timedDisableInstr) begin
            next_disCount = DIS_W'(DISABLE_CYCLES);
        end
        if (entryTake) begin
            events[EV_ENTRY] = 1'b1;
            events[EV_TRAP] = trapAny;
            if (!trapAny) begin
                next_statusLow = {statusLow[7:4], bestLvl[2:0], statusLow[0]};
            end
        end
        if (vectorValid && vectorAck && ctx.full) begin
            events[EV_STACK_ERR] = 1'b1;
        end
        // a still-set flag re-arbitrates the cycle after return
        if (ctx.pop) begin
            next_statusLow = ctx.topData;
        end
        // set wins over a write-one clear
        next_irqStat = irqStat;
        if (wrHit && regAddr == OFF_IRQ_STAT) begin
            next_irqStat = irqStat & ~regWdata[NUM_EV-1:0];
        end
        next_irqStat = next_irqStat | events;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags <= '0;
            enables <= '0;
            prios <= {NUM_SRC{PRIO_RESET}};
            nestDisable <= 1'b0;
            trapFlags <= '0;
            statusLow <= 8'h00;
            disCount <= '0;
            irqStat <= '0;
            irqMask <= '0;
        end else if (ce) begin
            flags <= next_flags;
            enables <= next_enables;
            prios <= next_prios;
            nestDisable <= next_nestDisable;
            trapFlags <= next_trapFlags;
            statusLow <= next_statusLow;
            disCount <= next_disCount;
            irqStat <= next_irqStat;
            irqMask <= next_irqMask;
        end
    end

    assign irq = |(irqStat & irqMask);

    ////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe
    logic [DATA_W-1:0] rdMux;
    always_comb begin
        rdMux = RESET_ZERO;
        case (regAddr)
            OFF_FLAGS: rdMux = flags;
            OFF_ENABLE: rdMux = enables;
            OFF_PRIO0, OFF_PRIO1, OFF_PRIO2, OFF_PRIO3: begin
                for (int k = 0; k < 4; k++) begin
                    rdMux[k*4 +: PRIO_W] = prios[(int'(regAddr - OFF_PRIO0) * 4 + k) * PRIO_W +: PRIO_W];
                end
            end
            OFF_CONTROL: rdMux = {nestDisable, 7'h00, trapFlags};
            OFF_CPU_LVL: rdMux = {8'h00, statusLow};
            OFF_VECTOR: rdMux = {vectorValid, 10'h000, vectorNum};
            OFF_IRQ_STAT: rdMux = {13'h0, irqStat};
            OFF_IRQ_MASK: rdMux = {13'h0, irqMask};
            default: rdMux = RESET_ZERO;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regRdata <= RESET_ZERO;
        end else if (ce) begin
            regRdata <= regRd ? rdMux : RESET_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    trap_never_blocked_a: assert property (@(posedge clk) disable iff (sys_rst)
        (|trapFlags) |-> vectorValid && vectorNum[LVL_W])
        else $error("pending trap not presented");
    reset_prio_four_a: assert property (@(posedge clk)
        sys_rst |=> prios == {NUM_SRC{PRIO_RESET}})
        else $error("priority not four after reset");
    timed_disable_a: assert property (@(posedge clk) disable iff (sys_rst)
        (disCount != '0 && vectorValid && !vectorNum[LVL_W]) |-> bestLvl == LVL_MAX_USER)
        else $error("low level passed timed disable");
    above_cpu_a: assert property (@(posedge clk) disable iff (sys_rst)
        (vectorValid && !vectorNum[LVL_W]) |-> bestLvl > cpuLevel)
        else $error("vector not above cpu level");
    flag_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && |srcRise) |=> (flags & $past(srcRise)) == $past(srcRise))
        else $error("request not latched");
    nest_block_a: assert property (@(posedge clk) disable iff (sys_rst)
        (nestDisable && !ctx.empty && !trapAny) |-> !vectorValid)
        else $error("nested entry while nesting disabled");
    return_restore_a: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && ctx.pop) |=> statusLow == $past(ctx.topData))
        else $error("status not restored");
    disabled_src_a: assert property (@(posedge clk) disable iff (sys_rst)
        (vectorValid && !vectorNum[LVL_W]) |-> prios[vectorNum[SRC_W-1:0]*PRIO_W +: PRIO_W] != PRIO_OFF)
        else $error("disabled source vectored");
endmodule

// *** include/intc_pkg.sv ***
package intc_pkg;
    // source and level geometry
    localparam int NUM_SRC = 16;
    localparam int PRIO_W = 3;
    localparam int LVL_W = 4;
    localparam int SRC_W = 4;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int NUM_TRAP = 8;
    localparam int TRAP_W = 3;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    // priority encodings
    localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
    localparam logic [LVL_W-1:0] LVL_MAX_USER = 4'h7;
    localparam logic [LVL_W-1:0] LVL_TRAP_BASE = 4'h8;
    localparam logic [LVL_W-1:0] LVL_DISABLE_TOP = 4'h6;
    localparam logic [7:0] MASK_ALL_OR = 8'h0e;
    // register word offsets
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_ENABLE = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_PRIO0 = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_PRIO1 = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_PRIO2 = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_PRIO3 = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h6;
    localparam logic [ADDR_W-1:0] OFF_CPU_LVL = 4'h7;
    localparam logic [ADDR_W-1:0] OFF_VECTOR = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 4'h9;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'ha;
    // control word fields
    localparam int CTL_NEST_DIS = 15;
    localparam int CTL_TRAP_LSB = 0;
    // irq status bits
    localparam int EV_ENTRY = 0;
    localparam int EV_TRAP = 1;
    localparam int EV_STACK_ERR = 2;
    localparam int NUM_EV = 3;
    // timed-disable period
    localparam int DISABLE_CYCLES = 16;
    localparam int DIS_W = 5;
    localparam logic [DATA_W-1:0] RESET_ZERO = 16'h0000;
endpackage

// *** include/ctx_if.sv ***
`timescale 1ns/10ps
// saved-context stack port between controller and its stack
interface ctx_if;
    logic push;
    logic pop;
    logic [7:0] pushData;
    logic [7:0] topData;
    logic empty;
    logic full;
    modport ctrl (output push, output pop, output pushData, input topData, input empty, input full);
    modport stack (input push, input pop, input pushData, output topData, output empty, output full);
endinterface

// *** core/ctx_stack.sv ***
`timescale 1ns/10ps
module ctx_stack
    import intc_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    // clocking
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // context port
    ctx_if.stack ctx
);
    logic [7:0] mem [DEPTH];
    logic [SP_W:0] sp;
    logic [SP_W:0] next_sp;

    // pointer moves on push or pop, never past the ends
    always_comb begin
        next_sp = sp;
        if (ctx.push && !ctx.full) begin
            next_sp = sp + 1'b1;
        end else if (ctx.pop && !ctx.empty) begin
            next_sp = sp - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sp <= '0;
        end else if (ce) begin
            sp <= next_sp;
            if (ctx.push && !ctx.full) begin
                mem[sp[SP_W-1:0]] <= ctx.pushData;
            end
        end
    end

    assign ctx.empty = (sp == '0);
    assign ctx.full = (sp == (SP_W+1)'(DEPTH));
    assign ctx.topData = ctx.empty ? 8'h00 : mem[3'(sp - 1'b1)];
endmodule

// *** tb/core_model.sv ***
`timescale 1ns/10ps
// core stand-in: takes a vector after a chosen latency, returns on request
module core_model (
    // clocking
    input wire logic clk,
    input wire logic sys_rst,
    // bench controls
    input wire logic autoAck,
    input wire logic retReq,
    input wire logic [3:0] lat,
    // controller side
    input wire logic vectorValid,
    output logic vectorAck,
    output logic returnInstr
);
    int waitCnt;
    initial begin
        vectorAck = 1'b0;
        returnInstr = 1'b0;
    end
    // one-cycle ack; skipped right after an ack since the new level lands one edge later
    always @(posedge clk) begin
        vectorAck <= 1'b0;
        returnInstr <= retReq;
        if (sys_rst || !autoAck || vectorValid !== 1'b1 || vectorAck) begin
            waitCnt <= 0;
        end else if (waitCnt >= lat) begin
            vectorAck <= 1'b1;
            waitCnt <= 0;
        end else begin
            waitCnt <= waitCnt + 1;
        end
    end
endmodule

// *** tb/priority_interrupt_controller_tb.sv ***
`timescale 1ns/10ps
module priority_interrupt_controller_tb
    import intc_pkg::*;
;
    logic clk, sys_rst, ce, regWr, regRd, vectorAck, returnInstr, timedDisableInstr;
    logic vectorValid, irq, autoAck, retReq;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata, regRdata, v, mf, me;
    logic [NUM_SRC-1:0] srcReq;
    logic [NUM_TRAP-1:0] trapReq;
    logic [LVL_W:0] vectorNum;
    logic [LVL_W-1:0] cpuLevel;
    logic [31:0] seed;
    int nFail, testsRun, ml, save, mp[NUM_SRC], stk[$];

    priority_interrupt_controller u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .srcReq(srcReq),
        .trapReq(trapReq), .vectorAck(vectorAck), .returnInstr(returnInstr),
        .timedDisableInstr(timedDisableInstr), .vectorValid(vectorValid), .vectorNum(vectorNum),
        .cpuLevel(cpuLevel), .irq(irq));
    core_model u_core (.clk(clk), .sys_rst(sys_rst), .autoAck(autoAck), .retReq(retReq), .lat(4'h2),
        .vectorValid(vectorValid), .vectorAck(vectorAck), .returnInstr(returnInstr));

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // reference level stack follows entries and returns
    always @(posedge clk) begin
        // every entry, trap too, saves the level; only user entries change it
        if (vectorAck === 1'b1) begin
            stk.push_back(ml);
            if (vectorNum[LVL_W] === 1'b0) ml = mp[vectorNum[3:0]];
        end
        if (returnInstr === 1'b1 && stk.size() > 0) ml = stk.pop_back();
    end
    ////////////////////////////////////////
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    // strict compare, so ties keep the lowest source number
    function automatic int expv();
        int b, bp;
        b = -1;
        bp = ml;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (mf[s] && me[s] && mp[s] > bp) begin
                b = s;
                bp = mp[s];
            end
        end
        return b;
    endfunction
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            nFail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkVec();
        int e;
        logic [5:0] got, exp;
        e = expv();
        got = (vectorValid === 1'b1) ? {1'b1, vectorNum} : {vectorValid, 5'h00};
        exp = (e < 0) ? 6'h00 : {2'b10, e[3:0]};
        chk16({10'h000, got}, {10'h000, exp});
    endtask
    task automatic noVec();
        chk16({15'h0000, vectorValid}, 16'h0000);
    endtask
    // write strobe for one cycle, then mirror into the reference
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
        case (a)
            OFF_FLAGS: mf = d;
            OFF_ENABLE: me = d;
            OFF_CPU_LVL: ml = d[3:1];
            OFF_PRIO0, OFF_PRIO1, OFF_PRIO2, OFF_PRIO3: begin
                for (int k = 0; k < 4; k++) mp[(a - OFF_PRIO0) * 4 + k] = d[4*k+:3];
            end
            default: ;
        endcase
        #1;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk16(regRdata, exp);
    endtask
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // bounded wait for the core to take a vector
    task automatic takeVec();
        int n;
        n = 0;
        autoAck <= 1'b1;
        while (vectorAck !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 50) begin
            nFail++;
            finish_test();
        end
        autoAck <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic ret();
        @(posedge clk);
        retReq <= 1'b1;
        @(posedge clk);
        retReq <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////
    // main sequence
    initial begin
        seed = 32'd35413;
        {ce, sys_rst, regWr, regRd, timedDisableInstr, autoAck, retReq} = 7'b1100000;
        {regAddr, regWdata, srcReq, trapReq} = '0;
        {nFail, testsRun, ml, mf, me} = '0;
        foreach (mp[i]) mp[i] = 4;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        rd(OFF_FLAGS, 16'h0000);
        rd(OFF_ENABLE, 16'h0000);
        for (int w = 0; w < 4; w++) rd(OFF_PRIO0 + w[3:0], 16'h4444);
        rd(4'hb, 16'h0000);
        // random priorities, enables, flags and cpu level
        repeat (24) begin
            for (int w = 0; w < 4; w++) begin
                v = rnd();
                wr(OFF_PRIO0 + w[3:0], v);
                rd(OFF_PRIO0 + w[3:0], v & 16'h7777);
            end
            wr(OFF_ENABLE, rnd());
            wr(OFF_CPU_LVL, rnd() & 16'h000e);
            wr(OFF_FLAGS, rnd());
            chkVec();
        end
        for (int w = 0; w < 4; w++) wr(OFF_PRIO0 + w[3:0], 16'h5555);
        {ml, mf} = '0;
        wr(OFF_CPU_LVL, 16'h0000);
        wr(OFF_ENABLE, 16'h0006);
        wr(OFF_FLAGS, 16'h0006);
        chkVec();
        wr(OFF_PRIO0, 16'h5505);
        chkVec();
        // setup order, entry, and the vector presented again after return while the flag stays set
        for (int w = 0; w < 4; w++) wr(OFF_PRIO0 + w[3:0], 16'h0000);
        wr(OFF_PRIO0, 16'h5000);
        wr(OFF_FLAGS, 16'h0000);
        wr(OFF_ENABLE, 16'h0008);
        wr(OFF_IRQ_MASK, 16'h0000);
        @(posedge clk);
        srcReq[3] <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        mf[3] = 1'b1;
        rd(OFF_FLAGS, 16'h0008);
        chkVec();
        takeVec();
        chk16({12'h000, cpuLevel}, 16'h0005);
        chk16({15'h0000, irq}, 16'h0000);
        wr(OFF_IRQ_MASK, 16'h0001);
        chk16({15'h0000, irq}, 16'h0001);
        rd(OFF_IRQ_STAT, 16'h0001);
        wr(OFF_IRQ_STAT, 16'h0001);
        chk16({15'h0000, irq}, 16'h0000);
        @(posedge clk);
        srcReq[3] <= 1'b0;
        ret();
        chk16({12'h000, cpuLevel}, 16'h0000);
        chkVec();
        wr(OFF_FLAGS, 16'h0000);
        chkVec();
        // raise the level to mask users; a trap still gets through
        wr(OFF_PRIO0, 16'h7000);
        wr(OFF_FLAGS, 16'h0008);
        save = ml;
        // or of the mask constant lifts the level field to seven
        wr(OFF_CPU_LVL, 16'(save << 1) | 16'(MASK_ALL_OR));
        chkVec();
        @(posedge clk);
        trapReq[2] <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk16({10'h000, vectorValid, vectorNum}, 16'h0032);
        rd(OFF_CONTROL, 16'h0004);
        // trap entry saves context and raises both entry event bits
        takeVec();
        rd(OFF_IRQ_STAT, 16'h0003);
        @(posedge clk);
        trapReq[2] <= 1'b0;
        wr(OFF_CONTROL, 16'h00fb);
        chkVec();
        ret();
        chk16({12'h000, cpuLevel}, 16'h0007);
        wr(OFF_CPU_LVL, 16'(save << 1));
        chkVec();
        // timed disable holds back level 6 but not level 7
        wr(OFF_PRIO0, 16'h6000);
        @(posedge clk);
        timedDisableInstr <= 1'b1;
        @(posedge clk);
        timedDisableInstr <= 1'b0;
        #1;
        noVec();
        wr(OFF_PRIO0, 16'h7000);
        chkVec();
        wr(OFF_PRIO0, 16'h6000);
        noVec();
        repeat (DISABLE_CYCLES) @(posedge clk);
        #1;
        chkVec();
        // nesting disable keeps a running routine from preemption
        wr(OFF_CONTROL, 16'h8000);
        wr(OFF_PRIO0, 16'h3000);
        takeVec();
        wr(OFF_PRIO1, 16'h0006);
        wr(OFF_ENABLE, 16'h0018);
        wr(OFF_FLAGS, 16'h0018);
        noVec();
        wr(OFF_CONTROL, 16'h0000);
        chkVec();
        rd(OFF_VECTOR, 16'h8004);
        ret();
        // a write while the clock enable is low must not land
        @(posedge clk);
        ce <= 1'b0;
        wr(OFF_IRQ_MASK, 16'h0000);
        @(posedge clk);
        ce <= 1'b1;
        rd(OFF_IRQ_MASK, 16'h0001);
        finish_test();
    end
endmodule
